// *** logic/epv_pkg.sv ***
// Constants for exception priority and vectoring
// Summary of operation
// - Lowest priority number among pending events wins
// - Later pipeline entry means younger instruction
// - Reset first, fixed start address, return undefined
// - Debug halt second, debug address, first uncompleted
// - Unrecoverable error third, base plus zero
// - Protection multiple hit fourth, base plus four
// - Data bus error fifth, first uncompleted saved
// - Fetch bus error sixth, first uncompleted saved
// - NMI seventh, first uncompleted saved
// - Interrupt levels three..zero autovectored, priorities 8-11
// - Bad instruction address twelfth, offending PC saved
// - Instruction miss thirteenth, protection fourteenth
// - Debug breakpoint fifteenth, first uncompleted saved
// - Illegal sixteenth, unimplemented seventeenth, offending PC
// - Privilege violation eighteenth, offending PC saved
// - Coprocessor instruction raises absent exception, twentieth
// - Supervisor call, return address call plus two
// - Data address read 22, write 23
// - Data miss read 24, write 25
// - Data protection read 26, write 27
// - Never raise floating-point or page-modified events
package epv_pkg;
    localparam int NUM_EVT    = 28;
    localparam int NUM_SLOT   = 2;
    localparam int SEQ_W      = 4;
    localparam int PRIO_W     = 5;
    localparam int IDX_W      = 5;

    // Event indices: priority number minus one
    localparam logic [IDX_W-1:0] E_RESET   = 5'h00;
    localparam logic [IDX_W-1:0] E_DBGHALT = 5'h01;
    localparam logic [IDX_W-1:0] E_UNREC   = 5'h02;
    localparam logic [IDX_W-1:0] E_MULTHIT = 5'h03;
    localparam logic [IDX_W-1:0] E_BUSDATA = 5'h04;
    localparam logic [IDX_W-1:0] E_BUSFTCH = 5'h05;
    localparam logic [IDX_W-1:0] E_NMI     = 5'h06;
    localparam logic [IDX_W-1:0] E_IRQ3    = 5'h07;
    localparam logic [IDX_W-1:0] E_IRQ0    = 5'h0A;
    localparam logic [IDX_W-1:0] E_BRKPT   = 5'h0E;
    localparam logic [IDX_W-1:0] E_SCALL   = 5'h14;

    // Events that come from an instruction in the pipeline
    localparam logic [NUM_EVT-1:0] INSTR_EVT_MASK = 28'h7FBB800;
    // Events that never occur: floating point, page modified
    localparam logic [NUM_EVT-1:0] UNUSED_MASK    = 28'h8040000;
    // Events saving the first non-completed instruction
    localparam logic [NUM_EVT-1:0] FIRST_NC_MASK  = 28'h00047F2;

    localparam logic [31:0] RESET_ADDR = 32'h08000000;
    localparam logic [31:0] SCALL_RET_INC = 32'h00000002;

    // Handler offsets from the vector base, by event index
    localparam logic [NUM_EVT*9-1:0] OFFSET_TABLE = {
        9'h044, 9'h040, 9'h03C, 9'h070, 9'h060, 9'h038, 9'h034, 9'h100,
        9'h030, 9'h02C, 9'h028, 9'h024, 9'h020, 9'h01C, 9'h018, 9'h050,
        9'h014, 9'h000, 9'h000, 9'h000, 9'h000, 9'h010, 9'h00C, 9'h008,
        9'h004, 9'h000, 9'h000, 9'h000};
endpackage : epv_pkg

// *** logic/epv_pick_if.sv ***
// Pending vector and winner between top and picker
`timescale 1ns/10ps
`default_nettype none
interface epv_pick_if;
    logic [epv_pkg::NUM_EVT-1:0] pend;
    logic                        any;
    logic [epv_pkg::IDX_W-1:0]   win;
    modport req (output pend, input any, input win);
    modport pick (input pend, output any, output win);
endinterface : epv_pick_if
`default_nettype wire

// *** logic/epv_prio_pick.sv ***
// Lowest-index pending event picker
`timescale 1ns/10ps
`default_nettype none
module epv_prio_pick (
    epv_pick_if.pick pk
);
    logic [epv_pkg::NUM_EVT-1:0] seen;
    logic [epv_pkg::IDX_W-1:0]   enc [epv_pkg::NUM_EVT];

    genvar gi;
    generate
        for (gi = 0; gi < epv_pkg::NUM_EVT; gi = gi + 1) begin : g_chain
            if (gi == 0) begin : g_first
                assign seen[gi] = pk.pend[gi];
                assign enc[gi]  = '0;
            end else begin : g_next
                assign seen[gi] = seen[gi-1] | pk.pend[gi];
                // Keep the earlier (higher priority) winner
                assign enc[gi]  = seen[gi-1] ? enc[gi-1] : epv_pkg::IDX_W'(gi);
            end
        end
    endgenerate

    assign pk.any = seen[epv_pkg::NUM_EVT-1];
    assign pk.win = enc[epv_pkg::NUM_EVT-1];
endmodule : epv_prio_pick
`default_nettype wire

// *** logic/epv_top.sv ***
// Exception priority resolution and vector generation
`timescale 1ns/10ps
`default_nettype none
module epv_top (
    // Clock, reset, enable
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clk_en_in,
    // Vector base written by software
    input  wire logic [31:0] exception_vector_base_in,
    // Debug system
    input  wire logic        debug_halt_in,
    input  wire logic [31:0] debug_handler_addr_in,
    input  wire logic        debug_brkpt_in,
    // Internal error and protection unit
    input  wire logic        unrec_err_in,
    input  wire logic [31:0] unrec_pc_in,
    input  wire logic        mpu_multi_hit_in,
    input  wire logic [31:0] mpu_multi_hit_pc_in,
    // Bus errors
    input  wire logic        bus_err_data_in,
    input  wire logic        bus_err_fetch_in,
    // Non-maskable interrupt pin, active low
    input  wire logic        nmi_n_in,
    // Interrupt controller
    input  wire logic [3:0]  irq_req_in,
    input  wire logic [31:0] irq_autovec_in,
    // Pipeline
    input  wire logic [31:0] first_nc_pc_in,
    input  wire logic [1:0]  slot_vld_in,
    input  wire logic [7:0]  slot_seq_in,
    input  wire logic [63:0] slot_pc_in,
    input  wire logic [55:0] slot_exc_in,
    // Vector output
    output logic             exc_take_out,
    output logic [4:0]       exc_prio_out,
    output logic [31:0]      handler_addr_out,
    output logic [31:0]      ret_addr_out,
    output logic             ret_valid_out,
    output logic             fetch_redirect_out,
    output logic             slot_sel_out
);
    localparam int N  = epv_pkg::NUM_EVT;
    localparam int SW = epv_pkg::SEQ_W;

    // Registers
    logic        reset_pend_ff;
    logic        nmi_meta_ff;
    logic        nmi_sync_n_ff;
    logic        nmi_prev_n_ff;
    logic        nmi_pend_ff;
    logic        take_ff;
    logic [4:0]  prio_ff;
    logic [31:0] handler_ff;
    logic [31:0] ret_ff;
    logic        ret_vld_ff;
    logic        redirect_ff;
    logic        slot_sel_ff;

    // Slot fields
    logic [SW-1:0]   seq0;
    logic [SW-1:0]   seq1;
    logic [31:0]     pc0;
    logic [31:0]     pc1;
    logic [N-1:0]    exc0;
    logic [N-1:0]    exc1;
    logic            has0;
    logic            has1;
    logic [SW-1:0]   seq_diff;
    logic            slot0_older;
    logic            use_slot1;
    logic [N-1:0]    instr_evt;
    logic [31:0]     instr_pc;

    // Resolution
    logic [N-1:0]    async_evt;
    logic [N-1:0]    all_evt;
    logic            can_take;
    logic [4:0]      win;
    logic            any;
    logic [8:0]      win_ofs;
    logic [31:0]     base_addr;
    logic [31:0]     nxt_handler;
    logic [31:0]     offending_pc;
    logic [31:0]     nxt_ret;
    logic            nxt_ret_vld;
    logic            win_first_nc;
    logic            win_is_irq;
    logic            win_is_unrec;
    logic            win_is_multhit;
    logic            nmi_fall;
    logic            nmi_taken;

    epv_pick_if pk_if ();

    epv_prio_pick u_pick (
        .pk (pk_if.pick)
    );

    // Slot decode; 19 and 28 never enter
    assign seq0 = slot_seq_in[SW-1:0];
    assign seq1 = slot_seq_in[2*SW-1:SW];
    assign pc0  = slot_pc_in[31:0];
    assign pc1  = slot_pc_in[63:32];
    assign exc0 = {slot_exc_in[27:0] & epv_pkg::INSTR_EVT_MASK & ~epv_pkg::UNUSED_MASK};
    assign exc1 = {slot_exc_in[55:28] & epv_pkg::INSTR_EVT_MASK & ~epv_pkg::UNUSED_MASK};
    assign has0 = slot_vld_in[0] & (|exc0);
    assign has1 = slot_vld_in[1] & (|exc1);

    // Slot 1 younger when it entered later, modulo tag wrap
    assign seq_diff    = seq1 - seq0;
    assign slot0_older = (seq_diff != '0) & ~seq_diff[SW-1];
    assign use_slot1   = has1 & (~has0 | ~slot0_older);
    assign instr_evt   = use_slot1 ? exc1 : (has0 ? exc0 : '0);
    assign instr_pc    = use_slot1 ? pc1 : pc0;

    // Events outside the instruction stream
    assign async_evt[0]  = reset_pend_ff;
    assign async_evt[1]  = debug_halt_in;
    assign async_evt[2]  = unrec_err_in;
    assign async_evt[3]  = mpu_multi_hit_in;
    assign async_evt[4]  = bus_err_data_in;
    assign async_evt[5]  = bus_err_fetch_in;
    assign async_evt[6]  = nmi_pend_ff;
    assign async_evt[10:7] = {irq_req_in[0], irq_req_in[1], irq_req_in[2],
                              irq_req_in[3]};
    assign async_evt[13:11] = '0;
    assign async_evt[14] = debug_brkpt_in;
    assign async_evt[N-1:15] = '0;

    // One flush cycle follows every take
    assign can_take   = ~take_ff;
    assign all_evt    = (async_evt | instr_evt) & ~epv_pkg::UNUSED_MASK;
    assign pk_if.pend = can_take ? all_evt : '0;
    assign win        = pk_if.win;
    assign any        = pk_if.any;

    // Handler address selection
    assign win_ofs     = epv_pkg::OFFSET_TABLE[win*9 +: 9];
    assign base_addr   = exception_vector_base_in + {23'h000000, win_ofs};
    assign win_is_irq  = (win >= epv_pkg::E_IRQ3) & (win <= epv_pkg::E_IRQ0);
    assign nxt_handler = (win == epv_pkg::E_RESET)   ? epv_pkg::RESET_ADDR :
                         (win == epv_pkg::E_DBGHALT) ? debug_handler_addr_in :
                         win_is_irq                  ? irq_autovec_in :
                         base_addr;
    // Table offsets also

    // Return address selection
    assign win_first_nc   = epv_pkg::FIRST_NC_MASK[win];
    assign win_is_unrec   = (win == epv_pkg::E_UNREC);
    assign win_is_multhit = (win == epv_pkg::E_MULTHIT);
    assign offending_pc   = win_is_unrec   ? unrec_pc_in :
                            win_is_multhit ? mpu_multi_hit_pc_in :
                            instr_pc;
    assign nxt_ret = win_first_nc ? first_nc_pc_in :
                     (win == epv_pkg::E_SCALL) ? instr_pc + epv_pkg::SCALL_RET_INC :
                     offending_pc;
    assign nxt_ret_vld = (win != epv_pkg::E_RESET);

    // NMI falling edge, taken once per edge
    assign nmi_fall  = nmi_prev_n_ff & ~nmi_sync_n_ff;
    assign nmi_taken = any & can_take & (win == epv_pkg::E_NMI);

    // NMI pin synchroniser
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            nmi_meta_ff   <= 1'b1;
            nmi_sync_n_ff <= 1'b1;
            nmi_prev_n_ff <= 1'b1;
        end else if (clk_en_in) begin
            nmi_meta_ff   <= nmi_n_in;
            nmi_sync_n_ff <= nmi_meta_ff;
            nmi_prev_n_ff <= nmi_sync_n_ff;
        end
    end

    // NMI pending until taken, new edge wins
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            nmi_pend_ff <= 1'b0;
        end else if (clk_en_in) begin
            nmi_pend_ff <= nmi_fall | (nmi_pend_ff & ~nmi_taken);
        end
    end

    // Reset vector pending after release
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reset_pend_ff <= 1'b1;
        end else if (clk_en_in && any && can_take && win == epv_pkg::E_RESET) begin
            reset_pend_ff <= 1'b0;
        end
    end

    // Take strobe and vector registers
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            take_ff     <= 1'b0;
            redirect_ff <= 1'b0;
        end else if (clk_en_in) begin
            take_ff     <= any & can_take;
            redirect_ff <= any & can_take;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prio_ff     <= 5'h00;
            handler_ff  <= 32'h00000000;
            ret_ff      <= 32'h00000000;
            ret_vld_ff  <= 1'b0;
            slot_sel_ff <= 1'b0;
        end else if (clk_en_in && any && can_take) begin
            prio_ff     <= win + 5'h01;
            handler_ff  <= nxt_handler;
            ret_ff      <= nxt_ret_vld ? nxt_ret : 32'h00000000;
            ret_vld_ff  <= nxt_ret_vld;
            slot_sel_ff <= use_slot1;
        end
    end

    assign exc_take_out       = take_ff;
    assign exc_prio_out       = prio_ff;
    assign handler_addr_out   = handler_ff;
    assign ret_addr_out       = ret_ff;
    assign ret_valid_out      = ret_vld_ff;
    assign fetch_redirect_out = redirect_ff;
    assign slot_sel_out       = slot_sel_ff;
endmodule : epv_top
`default_nettype wire

// *** verif/epv_far_model.sv ***
// Far-side requester that holds event levels until they are taken
`timescale 1ns/10ps
`default_nettype none
module epv_far_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // Raise pulses from the bench, take seen from the block
    input  wire logic [27:0] raise_in,
    input  wire logic        take_in,
    input  wire logic [4:0]  prio_in,
    // Held request levels, bit i is priority i+1
    output logic      [27:0] pend_out
);
    logic [27:0] pend_ff;
    logic [27:0] nxt_pend;
    logic [27:0] drop;

    assign drop     = take_in ? (28'h0000001 << (prio_in - 5'h01)) : 28'h0000000;
    assign nxt_pend = (pend_ff | raise_in) & ~drop;
    assign pend_out = pend_ff;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            pend_ff <= 28'h0000000;
        else
            pend_ff <= nxt_pend;
    end
endmodule // epv_far_model
`default_nettype wire

// *** verif/epv_top_assertions.sv ***
// Checker of take timing and vectors at the block's ports
`timescale 1ns/10ps
`default_nettype none
module epv_checker (
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    // Watched inputs
    input wire logic [31:0] exception_vector_base_in,
    input wire logic [31:0] debug_handler_addr_in,
    input wire logic [31:0] irq_autovec_in,
    input wire logic [31:0] first_nc_pc_in,
    input wire logic [63:0] slot_pc_in,
    // Watched outputs
    input wire logic        exc_take_out,
    input wire logic [4:0]  exc_prio_out,
    input wire logic [31:0] handler_addr_out,
    input wire logic [31:0] ret_addr_out,
    input wire logic        ret_valid_out,
    input wire logic        fetch_redirect_out,
    input wire logic        slot_sel_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_take_redirect: assert property (
        exc_take_out == fetch_redirect_out) else $error("redirect differs from take");
    a_flush_gap: assert property (
        exc_take_out |=> !exc_take_out) else $error("take in flush cycle");
    a_prio_legal: assert property (
        exc_take_out |-> exc_prio_out inside {[1:18], [20:27]}) else $error("bad priority");
    a_reset_vec: assert property (
        exc_take_out && exc_prio_out == 5'h01 |-> handler_addr_out == 32'h08000000
        && !ret_valid_out) else $error("reset vector wrong");
    a_debug_addr: assert property (
        exc_take_out && exc_prio_out == 5'h02 |-> handler_addr_out == debug_handler_addr_in
        && ret_addr_out == first_nc_pc_in) else $error("debug halt vector wrong");
    a_irq_autovec: assert property (
        exc_take_out && exc_prio_out inside {[8:11]} |-> handler_addr_out == irq_autovec_in
        && ret_addr_out == first_nc_pc_in) else $error("interrupt vector wrong");
    a_first_nc: assert property (
        exc_take_out && exc_prio_out inside {5, 6, 7, 15} |-> ret_addr_out == first_nc_pc_in
        && ret_valid_out) else $error("return address wrong");
    a_scall_ret: assert property (
        exc_take_out && exc_prio_out == 5'h15 |->
        handler_addr_out == exception_vector_base_in + 32'h00000100 && ret_addr_out ==
        (slot_sel_out ? slot_pc_in[63:32] : slot_pc_in[31:0]) + 32'h00000002)
        else $error("supervisor call vector wrong");
    a_vector_hold: assert property (
        !exc_take_out |-> $stable(handler_addr_out) && $stable(exc_prio_out))
        else $error("vector changed without take");
endmodule // epv_checker
bind epv_top epv_checker u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .exception_vector_base_in(exception_vector_base_in),
    .debug_handler_addr_in(debug_handler_addr_in), .irq_autovec_in(irq_autovec_in),
    .first_nc_pc_in(first_nc_pc_in), .slot_pc_in(slot_pc_in), .exc_take_out(exc_take_out),
    .exc_prio_out(exc_prio_out), .handler_addr_out(handler_addr_out),
    .ret_addr_out(ret_addr_out), .ret_valid_out(ret_valid_out),
    .fetch_redirect_out(fetch_redirect_out), .slot_sel_out(slot_sel_out));
`default_nettype wire

// *** verif/exception_priority_vectoring_bench.sv ***
// Bench for exception priority and vectoring
`timescale 1ns/10ps
`default_nettype none
module exception_priority_vectoring_bench;
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        en = 1'b1;
    logic [31:0] base = 32'h20000000;
    logic [1:0]  vld = 2'h1;
    logic [7:0]  seq = 8'h21;
    logic [27:0] raise = 28'h0000000;
    logic [27:0] s1_exc = 28'h0000000;
    logic [27:0] pend;
    logic        take, redir, sel, rvld;
    logic [4:0]  prio;
    logic [31:0] hnd, ret;
    int          bad_count = 0;
    int          compares = 0;
    int          cycles = 0;
    wire  [31:0] dbg = base ^ 32'h00004000, irqv = base ^ 32'h00005000, nc = base ^ 32'h00001000;
    wire  [31:0] upc = base ^ 32'h00001100, mpc = base ^ 32'h00001200, pc0 = base ^ 32'h00001300;
    wire  [31:0] pc1 = base ^ 32'h00001400;
    logic [8:0]  off [28] = '{9'h000, 9'h000, 9'h000, 9'h004, 9'h008, 9'h00C, 9'h010, 9'h000,
        9'h000, 9'h000, 9'h000, 9'h014, 9'h050, 9'h018, 9'h01C, 9'h020, 9'h024, 9'h028, 9'h02C,
        9'h030, 9'h100, 9'h034, 9'h038, 9'h060, 9'h070, 9'h03C, 9'h040, 9'h044};

    epv_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(en),
        .exception_vector_base_in(base), .debug_halt_in(pend[1]), .debug_handler_addr_in(dbg),
        .debug_brkpt_in(pend[14]), .unrec_err_in(pend[2]), .unrec_pc_in(upc),
        .mpu_multi_hit_in(pend[3]), .mpu_multi_hit_pc_in(mpc), .bus_err_data_in(pend[4]),
        .bus_err_fetch_in(pend[5]), .nmi_n_in(~pend[6]), .irq_req_in({pend[7], pend[8],
        pend[9], pend[10]}), .irq_autovec_in(irqv), .first_nc_pc_in(nc), .slot_vld_in(vld),
        .slot_seq_in(seq), .slot_pc_in({pc1, pc0}),
        .slot_exc_in({s1_exc, pend & 28'h7FBB800}), .exc_take_out(take), .exc_prio_out(prio),
        .handler_addr_out(hnd), .ret_addr_out(ret), .ret_valid_out(rvld),
        .fetch_redirect_out(redir), .slot_sel_out(sel));
    epv_far_model u_far (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .raise_in(raise),
        .take_in(take), .prio_in(prio), .pend_out(pend));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    task automatic report_and_stop();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_take();
        int n;
        n = 0;
        while (take !== 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        check("take", {31'h0, take}, 32'h1);
        check("redirect", {31'h0, redir}, 32'h1);
    endtask

    task automatic check_take(input int p, input logic s);
        logic [31:0] eh, er, pc;
        pc = s ? pc1 : pc0;
        eh = (p == 2) ? dbg : (p inside {[8:11]}) ? irqv : base + {23'h0, off[p-1]};
        er = (p inside {2, [5:11], 15}) ? nc : (p == 3) ? upc : (p == 4) ? mpc : pc;
        if (p == 21)
            er = pc + 32'h00000002;
        wait_take();
        check("prio", {27'h0, prio}, p);
        check("handler", hnd, eh);
        check("return", ret, er);
        check("ret valid", {31'h0, rvld}, 32'h1);
        if (p > 11 && p != 15)
            check("slot", {31'h0, sel}, {31'h0, s});
        @(negedge clk_in);
    endtask

    task automatic t_reset();
        wait_take();
        check("prio", {27'h0, prio}, 32'h1);
        check("handler", hnd, 32'h08000000);
        check("ret valid", {31'h0, rvld}, 32'h0);
        @(negedge clk_in);
    endtask

    task automatic t_each();
        for (int b = 0; b < 2; b++) begin
            base = b ? 32'h00010000 : 32'h20000000;
            for (int p = 2; p < 28; p++) begin
                if (p != 19) begin
                    raise = 28'h0000001 << (p - 1);
                    @(negedge clk_in);
                    raise = 28'h0000000;
                    check_take(p, 1'b0);
                end
            end
        end
    endtask

    task automatic t_all();
        raise = 28'h7FBFFFE;
        @(negedge clk_in);
        raise = 28'h0000000;
        for (int p = 2; p < 28; p++)
            if (p != 19)
                check_take(p, 1'b0);
    endtask

    task automatic t_age();
        vld = 2'h0;
        seq = 8'h45;
        s1_exc = 28'h0008000;
        raise = 28'h0000800;
        repeat (2) @(negedge clk_in);
        raise = 28'h0000000;
        vld = 2'h3;
        check_take(16, 1'b1);
        s1_exc = 28'h0000000;
        check_take(12, 1'b0);
        seq = 8'h21;
        vld = 2'h1;
    endtask

    task automatic t_unused();
        int n;
        n = 0;
        vld = 2'h3;
        s1_exc = 28'h8040000;
        repeat (12) begin
            @(negedge clk_in);
            if (take === 1'b1)
                n++;
        end
        check("unused takes", n, 32'h0);
        s1_exc = 28'h0000000;
        vld = 2'h1;
    endtask

    task automatic t_freeze();
        int n;
        n = 0;
        en = 1'b0;
        raise = 28'h0000002;
        @(negedge clk_in);
        raise = 28'h0000000;
        repeat (6) begin
            @(negedge clk_in);
            if (take === 1'b1)
                n++;
        end
        check("frozen takes", n, 32'h0);
        en = 1'b1;
        check_take(2, 1'b0);
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(negedge clk_in);
        sys_rst_in = 1'b0;
        t_reset();
        t_each();
        t_all();
        t_age();
        t_unused();
        t_freeze();
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        t_reset();
        report_and_stop();
    end
endmodule // exception_priority_vectoring_bench
`default_nettype wire
